//--- shared/msps_params.svh
// Constants of the microstep phase sequencer: clock, timing counts and register map.
// Assumes it is included once per compilation unit by its bare name.
`ifndef MSPS_PARAMS_SVH
`define MSPS_PARAMS_SVH

// ==========================================================
// Timing
`define MSPS_CLK_HZ 10000000
`define MSPS_CHOP_HZ 47000
`define MSPS_CHOP_CYCLES (`MSPS_CLK_HZ / `MSPS_CHOP_HZ)
`define MSPS_FILT_NS 1000
`define MSPS_FILT_CYCLES ((`MSPS_FILT_NS * (`MSPS_CLK_HZ / 1000000) + 999) / 1000)

// ==========================================================
// Position and levels
`define MSPS_ORIGIN 6'h08
`define MSPS_QTR 5'h10
`define MSPS_FULL 7'h64
`define MSPS_SYNC_RST 14'h03ff
`define MSPS_PIN_IDLE 1'b1

// ==========================================================
// Register map
`define MSPS_ADDR_CTRL 12'h000
`define MSPS_ADDR_STAT 12'h004
`define MSPS_CTRL_HOLD 0
`define MSPS_CTRL_RST 1'b0

`endif

//--- shared/msps_pkg.sv
// Types shared by the microstep phase sequencer.
// Assumes nothing of its surroundings.
package msps_pkg;
   typedef logic [5:0] msps_pos_t;
   typedef logic [6:0] msps_level_t;
   typedef enum logic [2:0] {
      MSPS_TWO,
      MSPS_ONE_TWO,
      MSPS_W12,
      MSPS_2W12,
      MSPS_4W12
   } msps_excite_t;
endpackage : msps_pkg

//--- hw/msps_sequencer.sv
// Microstep phase sequencer with per-phase chopper latches and an APB status port.
// Assumes all pins but the APB ones come from outside the clock domain and APB runs on CORE_CLK_IN.
`timescale 1ns/1ps
`include "msps_params.svh"

module msps_sequencer
   import msps_pkg::*;
#(
   parameter int CHOP_CYCLES = `MSPS_CHOP_CYCLES,
   parameter int FILT_CYCLES = `MSPS_FILT_CYCLES
) (
   input wire logic CORE_CLK_IN, // 10 MHz system clock
   input wire logic RST_IN, // async reset, high
   input wire logic RESET_N_IN, // host reset pin, low
   input wire logic STEP_CLK_IN, // step clock pin
   input wire logic DIRECTION_SELECT_IN, // high clockwise
   input wire logic MODE_BIT_LOW_IN, // excitation mode low bit
   input wire logic MODE_BIT_HIGH_IN, // excitation mode high bit
   input wire logic EDGE_SELECT_IN, // high rising only
   input wire logic LOCUS_BIT_A_IN, // vector locus bit a
   input wire logic LOCUS_BIT_B_IN, // vector locus bit b
   input wire logic RETURN_IN, // origin return pin
   input wire logic ENABLE_IN, // low enters hold
   input wire logic [3:0] CURRENT_REACHED_IN, // comparators A,Ab,B,Bb
   input wire logic PSEL_IN, // APB select
   input wire logic PENABLE_IN, // APB enable
   input wire logic PWRITE_IN, // APB direction
   input wire logic [11:0] PADDR_IN, // APB byte address
   input wire logic [31:0] PWDATA_IN, // APB write data
   output logic PREADY_OUT, // APB ready
   output logic [31:0] PRDATA_OUT, // APB read data
   output logic PSLVERR_OUT, // APB error
   output logic [3:0] DRIVE_OUT, // phase drives A,Ab,B,Bb
   output logic [6:0] REF_A_OUT, // A axis level, percent
   output logic [6:0] REF_B_OUT, // B axis level, percent
   output logic PHASE_MONITOR_FIRST_OUT, // quadrant bit first
   output logic PHASE_MONITOR_SECOND_OUT, // quadrant bit second
   output logic ORIGIN_MONITOR_OUT // low at origin
);

   // ==========================================================
   // Decode functions

   function automatic msps_excite_t excite_of(input logic edge_one, input logic [1:0] sel);
      msps_excite_t e;
      e = MSPS_TWO;
      unique case ({edge_one, sel})
         3'h4: e = MSPS_TWO;
         3'h5: e = MSPS_ONE_TWO;
         3'h6: e = MSPS_W12;
         3'h7: e = MSPS_2W12;
         3'h0: e = MSPS_ONE_TWO;
         3'h1: e = MSPS_W12;
         3'h2: e = MSPS_2W12;
         3'h3: e = MSPS_4W12;
      endcase
      return e;
   endfunction : excite_of

   function automatic msps_pos_t step_of(input msps_excite_t e);
      msps_pos_t s;
      s = 6'h01;
      unique case (e)
         MSPS_TWO: s = 6'h10;
         MSPS_ONE_TWO: s = 6'h08;
         MSPS_W12: s = 6'h04;
         MSPS_2W12: s = 6'h02;
         MSPS_4W12: s = 6'h01;
         default: s = 6'h01;
      endcase
      return s;
   endfunction : step_of

   // Columns: circular, outside one, outside two, inside.
   function automatic msps_level_t level_of(input logic [4:0] k, input logic [1:0] loc,
                                            input logic two);
      logic [27:0] row;
      msps_level_t v;
      row = 28'h0;
      case (k)
         5'h01: row = {7'h0e, 7'h0f, 7'h0f, 7'h0d};
         5'h02: row = {7'h14, 7'h19, 7'h17, 7'h13};
         5'h03: row = {7'h1f, 7'h22, 7'h21, 7'h1c};
         5'h04: row = {7'h28, 7'h2c, 7'h2a, 7'h27};
         5'h05: row = {7'h30, 7'h33, 7'h31, 7'h2d};
         5'h06: row = {7'h37, 7'h3e, 7'h39, 7'h36};
         5'h07: row = {7'h41, 7'h45, 7'h41, 7'h3e};
         5'h08: row = {7'h47, 7'h4d, 7'h47, 7'h45};
         5'h09: row = {7'h4d, 7'h52, 7'h4d, 7'h4a};
         5'h0a: row = {7'h53, 7'h58, 7'h55, 7'h52};
         5'h0b: row = {7'h58, 7'h5c, 7'h59, 7'h55};
         5'h0c: row = {7'h5c, 7'h5f, 7'h5f, 7'h5c};
         5'h0d: row = {7'h61, 7'h62, 7'h62, 7'h5e};
         5'h0e, 5'h0f, 5'h10: row = {4{`MSPS_FULL}};
         default: row = 28'h0;
      endcase
      unique case (loc)
         2'h3: v = row[27:21];
         2'h1: v = row[20:14];
         2'h2: v = row[13:7];
         2'h0: v = row[6:0];
      endcase
      if (two && (k != 5'h00)) begin
         v = `MSPS_FULL;
      end
      return v;
   endfunction : level_of

   // ==========================================================
   // Pin synchronisers

   localparam int FW = $clog2(FILT_CYCLES + 1);
   localparam int CW = $clog2(CHOP_CYCLES + 1);

   wire [13:0] pin_vec = {CURRENT_REACHED_IN, RESET_N_IN, ENABLE_IN, RETURN_IN,
                          STEP_CLK_IN, LOCUS_BIT_B_IN, LOCUS_BIT_A_IN, EDGE_SELECT_IN,
                          MODE_BIT_HIGH_IN, MODE_BIT_LOW_IN, DIRECTION_SELECT_IN};
   logic [13:0] sync1_reg;
   logic [13:0] sync2_reg;

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         sync1_reg <= `MSPS_SYNC_RST;
         sync2_reg <= `MSPS_SYNC_RST;
      end else begin
         sync1_reg <= pin_vec;
         sync2_reg <= sync1_reg;
      end
   end

   wire dir_s = sync2_reg[0];
   wire [1:0] mode_s = sync2_reg[2:1];
   wire edge_s = sync2_reg[3];
   wire [1:0] locus_s = {sync2_reg[5], sync2_reg[4]};
   wire [1:0] raw_s = {sync2_reg[7], sync2_reg[6]};
   wire en_s = sync2_reg[8];
   wire sw_rst = ~sync2_reg[9];
   wire [3:0] cmp_s = sync2_reg[13:10];

   logic ctrl_hold_reg;
   wire hold = ~en_s | ctrl_hold_reg;

   // ==========================================================
   // Edge filters: channel 0 step clock, channel 1 return

   wire [1:0] rise;
   wire [1:0] fall;
   genvar g;
   for (g = 0; g < 2; g++) begin : g_filt
      logic [FW-1:0] cnt_reg;
      logic lvl_reg;
      wire diff = raw_s[g] ^ lvl_reg;
      wire done = diff & (cnt_reg == FW'(FILT_CYCLES - 1));
      always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
         if (RST_IN) begin
            cnt_reg <= '0;
            lvl_reg <= `MSPS_PIN_IDLE;
         end else begin
            cnt_reg <= (done | ~diff | sw_rst) ? '0 : cnt_reg + 1'b1;
            lvl_reg <= (done | sw_rst) ? raw_s[g] : lvl_reg;
         end
      end
      assign rise[g] = done & raw_s[g] & ~sw_rst;
      assign fall[g] = done & ~raw_s[g] & ~sw_rst;
   end

   // ==========================================================
   // Position counter

   msps_pos_t pos_reg;
   wire msps_excite_t exc = excite_of(edge_s, mode_s);
   wire msps_pos_t step_amt = step_of(exc);
   wire msps_pos_t pos_up = pos_reg + step_amt;
   wire msps_pos_t pos_dn = pos_reg - step_amt;
   // rising edges; falling too when edge select low.
   wire step_ev = ~hold & (rise[0] | (fall[0] & ~edge_s));
   wire ret_ev = ~hold & rise[1];
   wire msps_pos_t pos_step = dir_s ? pos_up : pos_dn;
   // host reset to origin; hold leaves position.
   wire msps_pos_t pos_next = (sw_rst | ret_ev) ? `MSPS_ORIGIN :
                              step_ev ? pos_step : pos_reg;

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         pos_reg <= `MSPS_ORIGIN;
      end else begin
         pos_reg <= pos_next;
      end
   end

   // ==========================================================
   // Phase levels: each quadrant has sixteen microsteps

   wire [1:0] quad = pos_reg[5:4];
   wire [4:0] k_sin = {1'b0, pos_reg[3:0]};
   wire [4:0] k_cos = `MSPS_QTR - k_sin;
   wire two = (exc == MSPS_TWO);
   wire msps_level_t lv_sin = level_of(k_sin, locus_s, two);
   wire msps_level_t lv_cos = level_of(k_cos, locus_s, two);
   wire msps_level_t lv_a = quad[0] ? lv_sin : lv_cos;
   wire msps_level_t lv_b = quad[0] ? lv_cos : lv_sin;
   wire a_neg = quad[0] ^ quad[1];
   wire b_pos = quad[1];
   wire a_on = (lv_a != 7'h00);
   wire b_on = (lv_b != 7'h00);
   wire [3:0] phase_on = {~b_pos & b_on, b_pos & b_on, a_neg & a_on, ~a_neg & a_on};

   // ==========================================================
   // Chopper: fixed period, set at start, comparator resets

   logic [CW-1:0] chop_cnt_reg;
   logic [3:0] latch_reg;
   wire chop_start = (chop_cnt_reg == '0);
   wire chop_last = (chop_cnt_reg == CW'(CHOP_CYCLES - 1));
   // chopper count stands still in hold.
   wire [CW-1:0] chop_next = hold ? chop_cnt_reg : chop_last ? '0 : chop_cnt_reg + 1'b1;
   // set wins at period start; trip clears until next set.
   wire [3:0] latch_run = chop_start ? (phase_on | (latch_reg & ~cmp_s & phase_on)) :
                          (latch_reg & ~cmp_s & phase_on);
   wire [3:0] latch_next = hold ? latch_reg : latch_run;

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         chop_cnt_reg <= '0;
         latch_reg <= 4'h0;
      end else if (sw_rst) begin
         chop_cnt_reg <= '0;
         latch_reg <= 4'h0;
      end else begin
         chop_cnt_reg <= chop_next;
         latch_reg <= latch_next;
      end
   end

   // ==========================================================
   // Outputs and monitors

   wire [3:0] drive_next = latch_reg & phase_on & ~{4{hold | sw_rst}};
   wire mon_first_next = ~a_neg;
   wire mon_second_next = quad[0];
   wire origin_next = (pos_reg != `MSPS_ORIGIN);

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         DRIVE_OUT <= 4'h0;
         REF_A_OUT <= 7'h00;
         REF_B_OUT <= 7'h00;
         PHASE_MONITOR_FIRST_OUT <= 1'b1;
         PHASE_MONITOR_SECOND_OUT <= 1'b0;
         ORIGIN_MONITOR_OUT <= 1'b0;
      end else begin
         DRIVE_OUT <= drive_next;
         REF_A_OUT <= lv_a;
         REF_B_OUT <= lv_b;
         PHASE_MONITOR_FIRST_OUT <= mon_first_next;
         PHASE_MONITOR_SECOND_OUT <= mon_second_next;
         ORIGIN_MONITOR_OUT <= origin_next;
      end
   end

   // ==========================================================
   // APB slave: one wait state on every access

   wire apb_acc = PSEL_IN & PENABLE_IN;
   wire apb_first = apb_acc & ~PREADY_OUT;
   wire apb_done = apb_acc & PREADY_OUT;
   wire hit_ctrl = (PADDR_IN == `MSPS_ADDR_CTRL);
   wire hit_stat = (PADDR_IN == `MSPS_ADDR_STAT);
   wire [31:0] stat_word = {22'h0, hold, ORIGIN_MONITOR_OUT, PHASE_MONITOR_SECOND_OUT,
                            PHASE_MONITOR_FIRST_OUT, pos_reg};
   wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_hold_reg} : hit_stat ? stat_word : 32'h0;
   wire ctrl_wr = apb_done & PWRITE_IN & hit_ctrl;

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         PREADY_OUT <= 1'b0;
         PRDATA_OUT <= 32'h0;
         PSLVERR_OUT <= 1'b0;
         ctrl_hold_reg <= `MSPS_CTRL_RST;
      end else begin
         PREADY_OUT <= apb_first;
         PRDATA_OUT <= (apb_first & ~PWRITE_IN) ? rd_mux : 32'h0;
         PSLVERR_OUT <= apb_first & ~(hit_ctrl | hit_stat);
         ctrl_hold_reg <= ctrl_wr ? PWDATA_IN[`MSPS_CTRL_HOLD] : ctrl_hold_reg;
      end
   end

   // ==========================================================
   // Assertions

   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (RST_IN);

   wire quiet = ~hold & ~sw_rst & ~rise[1];

   sequence s_host_reset;
      sw_rst [*2];
   endsequence

   sequence s_at_origin;
      (REF_A_OUT == REF_B_OUT) && PHASE_MONITOR_FIRST_OUT && !PHASE_MONITOR_SECOND_OUT
         && !ORIGIN_MONITOR_OUT;
   endsequence

   AST_SET_ON:
      assert property (chop_start && phase_on[0] && !hold && !sw_rst |=> latch_reg[0])
      else $error("set pulse did not turn the phase on");

   AST_TRIP_OFF:
      assert property (cmp_s[0] && !chop_start && !sw_rst && !hold |=> !latch_reg[0] ##1
                       (!latch_reg[0] || $past(chop_start)))
      else $error("phase stayed on after current trip");

   AST_RISE_CW:
      assert property (rise[0] && quiet && dir_s |=> pos_reg == $past(pos_up))
      else $error("rising edge did not advance clockwise");

   AST_CCW:
      assert property (rise[0] && quiet && !dir_s |=> pos_reg == $past(pos_dn))
      else $error("rising edge did not retreat counterclockwise");

   AST_FALL_STEP:
      assert property (fall[0] && quiet && !edge_s |=> pos_reg != $past(pos_reg))
      else $error("falling edge did not step in dual-edge mode");

   AST_FALL_IGNORED:
      assert property (fall[0] && edge_s && !sw_rst && !rise[1] |=> $stable(pos_reg))
      else $error("falling edge stepped in rising-only mode");

   AST_FINE_STEP:
      assert property (rise[0] && quiet && !edge_s && (mode_s == 2'h3) && dir_s
                       |=> pos_reg == $past(pos_reg) + 6'h01)
      else $error("finest mode did not move one microstep");

   AST_RETURN:
      assert property (rise[1] && !hold && !sw_rst |=> pos_reg == `MSPS_ORIGIN)
      else $error("return edge did not reach origin");

   AST_HOLD_OFF:
      assert property (hold |=> DRIVE_OUT == 4'h0)
      else $error("drive active during hold");

   AST_HOLD_FREEZE:
      assert property (hold && !sw_rst |=> $stable(pos_reg) && $stable(chop_cnt_reg))
      else $error("state changed during hold");

   AST_RESET_ORIGIN:
      assert property (s_host_reset |=> s_at_origin)
      else $error("host reset did not place phases at origin");

   AST_MONITOR:
      assert property (1'b1 |=> PHASE_MONITOR_SECOND_OUT == $past(quad[0]) &&
                       PHASE_MONITOR_FIRST_OUT == !($past(a_neg)))
      else $error("quadrant monitor mismatch");

   AST_ORIGIN_MON:
      assert property ($changed(pos_reg) |=> ORIGIN_MONITOR_OUT == (pos_reg != `MSPS_ORIGIN))
      else $error("origin monitor mismatch");

endmodule : msps_sequencer

//--- verification/msps_host_model.sv
// Host controller model: drives the step clock, direction, mode and reset pins.
// Assumes the caller runs its tasks one at a time from the bench's main sequence.
`timescale 1ns/1ps

module msps_host_model #(
   parameter int HALF_CYCLES = 100,
   parameter int SETTLE_CYCLES = 63
) (
   input wire logic clk_in, // system clock
   output logic step_out, // step clock pin
   output logic dir_out, // direction pin
   output logic mode_lo_out, // mode bit low
   output logic mode_hi_out, // mode bit high
   output logic edge_sel_out, // edge select pin
   output logic ret_out, // origin return pin
   output logic rst_n_out // host reset pin
);
   // ==========================================================
   // Power-up levels
   // idle high, reset asserted
   initial begin
      step_out = 1'b1;
      dir_out = 1'b1;
      mode_lo_out = 1'b1;
      mode_hi_out = 1'b1;
      edge_sel_out = 1'b1;
      ret_out = 1'b1;
      rst_n_out = 1'b0;
   end

   // ==========================================================
   // Pin tasks
   // settle before edges
   task set_pins(input logic d, input logic e, input logic hi, input logic lo);
      @(posedge clk_in);
      dir_out <= d;
      edge_sel_out <= e;
      mode_hi_out <= hi;
      mode_lo_out <= lo;
      repeat (SETTLE_CYCLES) @(posedge clk_in);
   endtask : set_pins

   // half period of 10 us each
   task pulse_step();
      @(posedge clk_in);
      step_out <= 1'b0;
      repeat (HALF_CYCLES) @(posedge clk_in);
      step_out <= 1'b1;
      repeat (HALF_CYCLES) @(posedge clk_in);
   endtask : pulse_step

   task return_origin();
      @(posedge clk_in);
      ret_out <= 1'b0;
      repeat (HALF_CYCLES) @(posedge clk_in);
      ret_out <= 1'b1;
      repeat (HALF_CYCLES) @(posedge clk_in);
   endtask : return_origin

   task host_reset();
      @(posedge clk_in);
      rst_n_out <= 1'b0;
      repeat (HALF_CYCLES) @(posedge clk_in);
      rst_n_out <= 1'b1;
      repeat (HALF_CYCLES) @(posedge clk_in);
   endtask : host_reset
endmodule : msps_host_model

//--- verification/tb_microstep_phase_sequencer.sv
// Self-checking bench for the microstep phase sequencer.
// Assumes the host model file is compiled first and the design top is msps_sequencer.
`timescale 1ns/1ps

module tb_microstep_phase_sequencer;
   // A short chopper period keeps the latch checks quick.
   localparam int CHOP = 16;
   typedef struct {logic rd; logic [31:0] data; logic err;} msps_exp_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic step, dir, mlo, mhi, edge_sel, ret, rst_n;
   logic loc_a = 1'b1;
   logic loc_b = 1'b1;
   logic enable = 1'b1;
   logic [3:0] reached = 4'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, mon1, mon2, orig;
   logic [3:0] drive;
   logic [6:0] ref_a, ref_b;
   logic [5:0] pos;
   int errors = 0;
   int compares = 0;
   msps_exp_t exp_q[$];

   always #50 clk = ~clk;

   msps_host_model host (.clk_in(clk), .step_out(step), .dir_out(dir), .mode_lo_out(mlo),
      .mode_hi_out(mhi), .edge_sel_out(edge_sel), .ret_out(ret), .rst_n_out(rst_n));

   msps_sequencer #(.CHOP_CYCLES(CHOP)) uut (.CORE_CLK_IN(clk), .RST_IN(rst),
      .RESET_N_IN(rst_n), .STEP_CLK_IN(step), .DIRECTION_SELECT_IN(dir),
      .MODE_BIT_LOW_IN(mlo), .MODE_BIT_HIGH_IN(mhi), .EDGE_SELECT_IN(edge_sel),
      .LOCUS_BIT_A_IN(loc_a), .LOCUS_BIT_B_IN(loc_b), .RETURN_IN(ret), .ENABLE_IN(enable),
      .CURRENT_REACHED_IN(reached), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
      .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .DRIVE_OUT(drive), .REF_A_OUT(ref_a),
      .REF_B_OUT(ref_b), .PHASE_MONITOR_FIRST_OUT(mon1), .PHASE_MONITOR_SECOND_OUT(mon2),
      .ORIGIN_MONITOR_OUT(orig));

   // ==========================================================
   // Checking and reporting
   task check_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   task test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   always @(posedge clk) begin
      msps_exp_t e;
      if (pready === 1'b1) begin
         e = exp_q.pop_front();
         if (e.rd) check_val(prdata, e.data);
         check_val({31'h0, pslverr}, {31'h0, e.err});
      end
   end

   // ==========================================================
   // Bus and position helpers
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] ex, input logic err);
      int n;
      exp_q.push_back('{!wr, ex, err});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         test_done();
      end
   endtask : apb

   function automatic logic [31:0] stat_of(input logic [5:0] p, input logic h);
      logic [1:0] q;
      q = p[5:4];
      return {22'h0, h, (p != 6'h08), q[0], ~(q[1] ^ q[0]), p};
   endfunction : stat_of

   task read_stat(input logic h);
      apb(1'b0, 12'h004, 32'h0, stat_of(pos, h), 1'b0);
   endtask : read_stat

   task wait_a(input logic v);
      int n;
      n = 0;
      while (drive[0] !== v && n < 100) begin
         @(posedge clk);
         n++;
      end
      check_val({31'h0, drive[0]}, {31'h0, v});
   endtask : wait_a

   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      test_done();
   end

   // ==========================================================
   // Main sequence
   initial begin
      int s;
      int step_sz;
      logic d;
      logic [31:0] lv [4];
      lv = '{32'h45, 32'h4d, 32'h47, 32'h47};
      s = $urandom(89);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      host.host_reset();
      pos = 6'h08;
      read_stat(1'b0);
      for (int i = 0; i < 4; i++) begin
         loc_a <= i[0];
         loc_b <= i[1];
         repeat (10) @(posedge clk);
         check_val(32'(ref_a), lv[i]);
         check_val(32'(ref_b), lv[i]);
      end
      wait_a(1'b1);
      reached <= 4'h1;
      repeat (3) @(posedge clk);
      reached <= 4'h0;
      repeat (3) @(posedge clk);
      check_val(32'(drive), 32'h8);
      wait_a(1'b1);
      // Every edge mode and excitation code, random direction except in the finest mode.
      for (int e = 1; e >= 0; e--) begin
         for (int m = 0; m < 4; m++) begin
            // The finest mode always steps clockwise so its one-microstep check is reached.
            d = (e == 0 && m == 3) ? 1'b1 : 1'($urandom % 2);
            host.set_pins(d, e[0], m[1], m[0]);
            host.pulse_step();
            step_sz = (e != 0) ? (16 >> m) : (2 * (8 >> m));
            pos = d ? pos + 6'(step_sz) : pos - 6'(step_sz);
            read_stat(1'b0);
         end
      end
      host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
      host.pulse_step();
      pos = pos + 6'h02;
      host.return_origin();
      pos = 6'h08;
      read_stat(1'b0);
      enable <= 1'b0;
      repeat (10) @(posedge clk);
      check_val(32'(drive), 32'h0);
      host.pulse_step();
      read_stat(1'b1);
      enable <= 1'b1;
      host.pulse_step();
      pos = pos + 6'h02;
      read_stat(1'b0);
      apb(1'b1, 12'h000, 32'h1, 32'h0, 1'b0);
      apb(1'b0, 12'h000, 32'h0, 32'h1, 1'b0);
      read_stat(1'b1);
      apb(1'b1, 12'h004, 32'hffff_ffff, 32'h0, 1'b0);
      apb(1'b1, 12'h000, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
      read_stat(1'b0);
      host.pulse_step();
      pos = pos + 6'h02;
      host.host_reset();
      pos = 6'h08;
      read_stat(1'b0);
      test_done();
   end
endmodule : tb_microstep_phase_sequencer
